// [hw/tmc_consts.vh]
// constants for the tension mode discrete i/o control block
// assumes a single 200 MHz reference clock and a plain register port
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH

// ***********************************************
// clock and timing
// ***********************************************
`define TMC_CLK_MHZ         200
`define TMC_MS_NS           1000000
`define TMC_CLK_NS          5
`define TMC_MS_CYC          (`TMC_MS_NS / `TMC_CLK_NS)
`define TMC_MOVE_MIN_MS_RST 16'h000a

// ***********************************************
// register offsets (byte addresses)
// ***********************************************
`define TMC_ADDR_W          10
`define TMC_OFS_CTRL        10'h000
`define TMC_OFS_MOVE_MIN    10'h004
`define TMC_OFS_ZERO_BAND   10'h008
`define TMC_OFS_STATUS      10'h00c
`define TMC_OFS_DIAMETER    10'h010
`define TMC_OFS_DSET_BASE   10'h100
`define TMC_DSET_SEL        2'h1

// ***********************************************
// control register fields
// ***********************************************
`define TMC_CTRL_MODE_LSB   0
`define TMC_CTRL_MODE_MSB   1
`define TMC_CTRL_ANALOG     2
`define TMC_CTRL_DIR        3
`define TMC_CTRL_SEL1_LSB   4
`define TMC_CTRL_SEL1_MSB   5
`define TMC_CTRL_SEL2       6
`define TMC_CTRL_RST        7'h04

`define TMC_MODE_SIMPLE     2'h0
`define TMC_MODE_HIGH1      2'h1
`define TMC_MODE_HIGH2      2'h2
`define TMC_SEL1_NONE       2'h0
`define TMC_SEL1_MOTION     2'h1
`define TMC_SEL1_BRAKE      2'h2

// ***********************************************
// operation data sets
// ***********************************************
`define TMC_FW              24
`define TMC_SPD_W           13
`define TMC_F_SPEED         3'h0
`define TMC_F_TENSION       3'h1
`define TMC_F_THICK         3'h2
`define TMC_F_INIT_DIA      3'h3
`define TMC_F_FINAL_DIA     3'h4
`define TMC_F_TAPER         3'h5
`define TMC_F_MAT_INERTIA   3'h6
`define TMC_F_CORE_INERTIA  3'h7
`define TMC_RST_THICK       24'h00_0032
`define TMC_RST_INIT_DIA    24'h00_01f4
`define TMC_RST_FINAL_DIA   24'h00_03e8
`define TMC_RST_TAPER       24'h00_0064
`define TMC_ZERO_BAND_RST   13'h000a
`define TMC_UM_PER_MM       16'h03e8

`endif

// [hw/tmc_io_ctrl.v]
// discrete i/o control of a servo driver in tension control mode
// assumes pins arrive asynchronous, speed and status inputs come from
// logic on ref_clk, and software uses the plain register port
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.vh"

module tmc_io_ctrl #(
   parameter MS_CYC = `TMC_MS_CYC
) (
   // clock, reset, enable
   input  wire                     ref_clk,
   input  wire                     arst_n,
   input  wire                     clk_en,
   // discrete pins from the controller
   input  wire                     cw_in,
   input  wire                     ccw_in,
   input  wire                     diameter_reset_input,
   input  wire                     shaft_release_input,
   input  wire                     data_select_bit0,
   input  wire                     data_select_bit1,
   input  wire                     data_select_bit2,
   // drive side status, same clock
   input  wire                     alarm_active,
   input  wire                     remote_active,
   input  wire                     test_active,
   input  wire                     copy_active,
   input  wire                     motor_running,
   input  wire                     roll_rev_pulse,
   input  wire [`TMC_SPD_W-1:0]    detected_speed,
   input  wire [`TMC_SPD_W-1:0]    internal_speed_pot,
   input  wire [`TMC_SPD_W-1:0]    external_speed_in,
   // register port
   input  wire [`TMC_ADDR_W-1:0]   reg_addr,
   input  wire [31:0]              reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [31:0]              reg_rdata,
   // discrete outputs to the controller
   output reg                      ready_output,
   output reg                      motion_active_output,
   output reg                      brake_release_output,
   output reg                      speed_limited_output,
   output reg                      zero_speed_output,
   // motor loop commands
   output reg                      motor_enable,
   output reg                      motor_dir,
   output reg                      decel_request,
   output reg                      current_cut,
   output reg                      deviation_clear,
   output reg  [`TMC_SPD_W-1:0]    speed_limit_value,
   output reg  [`TMC_FW-1:0]       tension_cmd,
   output reg  [`TMC_FW-1:0]       thickness_cmd,
   output reg  [`TMC_FW-1:0]       taper_cmd,
   output reg  [`TMC_FW-1:0]       mat_inertia_cmd,
   output reg  [`TMC_FW-1:0]       core_inertia_cmd,
   output reg  [`TMC_FW-1:0]       diameter_um
);

   // ***********************************************
   // helpers
   // ***********************************************
   function [`TMC_FW-1:0] field_default;
      input [2:0] fld;
      begin
         case (fld)
            `TMC_F_THICK:     field_default = `TMC_RST_THICK;
            `TMC_F_INIT_DIA:  field_default = `TMC_RST_INIT_DIA;
            `TMC_F_FINAL_DIA: field_default = `TMC_RST_FINAL_DIA;
            `TMC_F_TAPER:     field_default = `TMC_RST_TAPER;
            default:          field_default = {`TMC_FW{1'b0}};
         endcase
      end
   endfunction

   function [`TMC_FW-1:0] mm_to_um;
      input [`TMC_FW-1:0] mm;
      reg   [39:0]        prod;
      begin
         prod     = mm * `TMC_UM_PER_MM;
         mm_to_um = prod[`TMC_FW-1:0];
      end
   endfunction

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   reg  [6:0] pin_s1_r;
   reg  [6:0] pin_s2_r;
   reg        wreset_prev_r;

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_r      <= 7'h00;
         pin_s2_r      <= 7'h00;
         wreset_prev_r <= 1'b0;
      end else if (clk_en) begin
         pin_s1_r      <= {data_select_bit2, data_select_bit1, data_select_bit0,
                           shaft_release_input, diameter_reset_input,
                           ccw_in, cw_in};
         pin_s2_r      <= pin_s1_r;
         wreset_prev_r <= pin_s2_r[2];
      end
   end

   wire       cw_s     = pin_s2_r[0];
   wire       ccw_s    = pin_s2_r[1];
   wire       wreset_s = pin_s2_r[2];
   wire       free_s   = pin_s2_r[3];
   wire [2:0] dsel_s   = pin_s2_r[6:4];
   wire       wreset_rise = wreset_s & ~wreset_prev_r;

   // ***********************************************
   // configuration registers
   // ***********************************************
   reg  [6:0]            ctrl_r;
   reg  [15:0]           move_min_ms_r;
   reg  [`TMC_SPD_W-1:0] zero_band_r;
   reg  [`TMC_FW-1:0]    dset_mem [0:63];
   reg  [2:0]            set_num_r;
   integer               i;

   wire [1:0] mode     = ctrl_r[`TMC_CTRL_MODE_MSB:`TMC_CTRL_MODE_LSB];
   wire       analog_en = ctrl_r[`TMC_CTRL_ANALOG];
   wire       dir_par  = ctrl_r[`TMC_CTRL_DIR];
   wire [1:0] sel1     = ctrl_r[`TMC_CTRL_SEL1_MSB:`TMC_CTRL_SEL1_LSB];
   wire       sel2_zv  = ctrl_r[`TMC_CTRL_SEL2];
   wire       high_mode = (mode == `TMC_MODE_HIGH1) | (mode == `TMC_MODE_HIGH2);
   wire       in_dset  = (reg_addr[9:8] == `TMC_DSET_SEL);
   wire [5:0] dset_idx = reg_addr[7:2];

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r        <= `TMC_CTRL_RST;
         move_min_ms_r <= `TMC_MOVE_MIN_MS_RST;
         zero_band_r   <= `TMC_ZERO_BAND_RST;
         set_num_r     <= 3'h0;
         for (i = 0; i < 64; i = i + 1) begin
            dset_mem[i] <= field_default(i[2:0]);
         end
      end else if (clk_en) begin
         if (reg_wr) begin
            case (reg_addr)
               `TMC_OFS_CTRL:      ctrl_r        <= reg_wdata[6:0];
               `TMC_OFS_MOVE_MIN:  move_min_ms_r <= reg_wdata[15:0];
               `TMC_OFS_ZERO_BAND: zero_band_r   <= reg_wdata[`TMC_SPD_W-1:0];
               default: begin
                  if (in_dset) begin
                     dset_mem[dset_idx] <= reg_wdata[`TMC_FW-1:0];
                  end
               end
            endcase
         end
         // set number follows the select pins only while cw is off
         if (!cw_s) begin
            set_num_r <= dsel_s;
         end
      end
   end

   // ***********************************************
   // selected data set
   // ***********************************************
   wire [5:0]          set_base  = {set_num_r, 3'h0};
   wire [`TMC_FW-1:0]  f_speed   = dset_mem[set_base | {3'h0, `TMC_F_SPEED}];
   wire [`TMC_FW-1:0]  f_tension = dset_mem[set_base | {3'h0, `TMC_F_TENSION}];
   wire [`TMC_FW-1:0]  f_thick   = dset_mem[set_base | {3'h0, `TMC_F_THICK}];
   wire [`TMC_FW-1:0]  f_init    = dset_mem[set_base | {3'h0, `TMC_F_INIT_DIA}];
   wire [`TMC_FW-1:0]  f_final   = dset_mem[set_base | {3'h0, `TMC_F_FINAL_DIA}];
   wire [`TMC_FW-1:0]  f_taper   = dset_mem[set_base | {3'h0, `TMC_F_TAPER}];
   wire [`TMC_FW-1:0]  f_mat     = dset_mem[set_base | {3'h0, `TMC_F_MAT_INERTIA}];
   wire [`TMC_FW-1:0]  f_core    = dset_mem[set_base | {3'h0, `TMC_F_CORE_INERTIA}];

   reg  [`TMC_SPD_W-1:0] limit_nxt;
   always @* begin
      if (analog_en && set_num_r == 3'h0) begin
         limit_nxt = internal_speed_pot;
      end else if (analog_en && set_num_r == 3'h1) begin
         limit_nxt = external_speed_in;
      end else begin
         limit_nxt = f_speed[`TMC_SPD_W-1:0];
      end
   end

   // ***********************************************
   // run control
   // ***********************************************
   wire inhibit   = alarm_active | free_s | remote_active | test_active | copy_active;
   wire ccw_run   = ccw_s & ~high_mode;
   wire run_req   = (cw_s | ccw_run) & ~inhibit;
   wire ready_nxt = ~(inhibit | cw_s | ccw_s);
   // winding when the initial diameter is below the final one
   wire winding   = (f_init < f_final);
   wire unwinding = (f_init > f_final);

   // ***********************************************
   // motion active minimum on time
   // ***********************************************
   // ms prescaler keeps the hold counter narrow; it restarts when motion starts, so the hold has no slack
   reg  [31:0] ms_pre_r;
   reg  [15:0] hold_ms_r;
   reg         motion_r;
   wire        ms_tick = (ms_pre_r == MS_CYC - 1);

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ms_pre_r  <= 32'h0000_0000;
         hold_ms_r <= 16'h0000;
         motion_r  <= 1'b0;
      end else if (clk_en) begin
         if (motor_running && !motion_r) begin
            motion_r  <= 1'b1;
            hold_ms_r <= move_min_ms_r;
            ms_pre_r  <= 32'h0000_0000;
         end else if (motion_r) begin
            ms_pre_r <= ms_tick ? 32'h0000_0000 : ms_pre_r + 32'h0000_0001;
            if (ms_tick && hold_ms_r != 16'h0000) begin
               hold_ms_r <= hold_ms_r - 16'h0001;
            end
            if (!motor_running && hold_ms_r == 16'h0000) begin
               motion_r <= 1'b0;
            end
         end
      end
   end

   // ***********************************************
   // roll diameter
   // ***********************************************
   wire [`TMC_FW-1:0] two_thick = {f_thick[`TMC_FW-2:0], 1'b0};
   wire [`TMC_FW-1:0] init_um   = mm_to_um(f_init);
   wire [`TMC_FW-1:0] final_um  = mm_to_um(f_final);
   wire [`TMC_FW:0]   dia_up    = {1'b0, diameter_um} + {1'b0, two_thick};

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         diameter_um <= {`TMC_FW{1'b0}};
      end else if (clk_en) begin
         if (wreset_rise && !motor_running) begin
            diameter_um <= init_um;
         end else if (high_mode && motor_running && roll_rev_pulse) begin
            // one layer per revolution, clamped at the final diameter
            if (winding) begin
               diameter_um <= (dia_up[`TMC_FW-1:0] > final_um || dia_up[`TMC_FW])
                              ? final_um : dia_up[`TMC_FW-1:0];
            end else if (unwinding) begin
               diameter_um <= (diameter_um < final_um + two_thick)
                              ? final_um : diameter_um - two_thick;
            end
         end
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ready_output         <= 1'b0;
         motion_active_output <= 1'b0;
         brake_release_output <= 1'b0;
         speed_limited_output <= 1'b0;
         zero_speed_output    <= 1'b0;
         motor_enable         <= 1'b0;
         motor_dir            <= 1'b0;
         decel_request        <= 1'b0;
         current_cut          <= 1'b0;
         deviation_clear      <= 1'b0;
         speed_limit_value    <= {`TMC_SPD_W{1'b0}};
         tension_cmd          <= {`TMC_FW{1'b0}};
         thickness_cmd        <= {`TMC_FW{1'b0}};
         taper_cmd            <= {`TMC_FW{1'b0}};
         mat_inertia_cmd      <= {`TMC_FW{1'b0}};
         core_inertia_cmd     <= {`TMC_FW{1'b0}};
      end else if (clk_en) begin
         ready_output         <= ready_nxt;
         motor_enable         <= run_req;
         if (run_req) begin
            motor_dir <= cw_s ? dir_par : ~dir_par;
         end
         // cw released: stopping ramp until the loop reports standstill
         decel_request        <= ~run_req & motor_running & ~free_s;
         current_cut          <= free_s;
         deviation_clear      <= free_s;
         motion_active_output <= (sel1 == `TMC_SEL1_MOTION) & motion_r;
         // brake released while driven or while the shaft is freed
         brake_release_output <= (sel1 == `TMC_SEL1_BRAKE)
                                 & (run_req | motor_running | free_s);
         speed_limited_output <= (detected_speed >= limit_nxt);
         zero_speed_output    <= sel2_zv & (detected_speed <= zero_band_r);
         speed_limit_value    <= limit_nxt;
         tension_cmd          <= f_tension;
         thickness_cmd        <= high_mode ? f_thick : {`TMC_FW{1'b0}};
         taper_cmd            <= high_mode ? f_taper : {`TMC_FW{1'b0}};
         mat_inertia_cmd      <= (mode == `TMC_MODE_HIGH2) ? f_mat
                                 : {`TMC_FW{1'b0}};
         core_inertia_cmd     <= (mode == `TMC_MODE_HIGH2) ? f_core
                                 : {`TMC_FW{1'b0}};
      end
   end

   // ***********************************************
   // register read
   // ***********************************************
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `TMC_OFS_CTRL:      reg_rdata <= {25'h000_0000, ctrl_r};
               `TMC_OFS_MOVE_MIN:  reg_rdata <= {16'h0000, move_min_ms_r};
               `TMC_OFS_ZERO_BAND: reg_rdata <= {19'h0_0000, zero_band_r};
               `TMC_OFS_STATUS:    reg_rdata <= {20'h0_0000, set_num_r, motion_r,
                                                  motor_enable, speed_limited_output,
                                                  zero_speed_output, ready_output,
                                                  free_s, ccw_s, cw_s, winding};
               `TMC_OFS_DIAMETER:  reg_rdata <= {8'h00, diameter_um};
               default: begin
                  if (in_dset) begin
                     reg_rdata <= {8'h00, dset_mem[dset_idx]};
                  end
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// [dv/tmc_io_ctrl_assertions.sv]
// checker for the tension mode discrete i/o block
// sees only the top module's ports; move_min and zero band left at reset values
`timescale 1ns/1ps
`default_nettype none
module tmc_io_ctrl_chk #(
   parameter MS_CYC = 10
) (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        arst_n,
   // inputs
   input wire logic        cw_in,
   input wire logic        shaft_release_input,
   input wire logic        alarm_active,
   input wire logic        motor_running,
   input wire logic        roll_rev_pulse,
   input wire logic [12:0] detected_speed,
   input wire logic        reg_rd,
   // outputs
   input wire logic [31:0] reg_rdata,
   input wire logic        ready_output,
   input wire logic        motion_active_output,
   input wire logic        speed_limited_output,
   input wire logic        zero_speed_output,
   input wire logic        motor_enable,
   input wire logic        decel_request,
   input wire logic        current_cut,
   input wire logic        deviation_clear,
   input wire logic [12:0] speed_limit_value,
   input wire logic [23:0] diameter_um
);
   // ****************************
   // helper counter
   // ****************************
   localparam int MIN_CYC = 10 * MS_CYC;
   logic [31:0] on_cnt_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         on_cnt_r <= 32'h0000_0000;
      else
         on_cnt_r <= motion_active_output ? on_cnt_r + 32'h0000_0001 : 32'h0000_0000;
   end
   // ****************************
   // properties
   // ****************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   chk_ready_alarm: assert property (alarm_active |=> !ready_output)
      else $error("ready on during alarm");
   chk_ready_cw: assert property (cw_in |-> ##3 !ready_output)
      else $error("ready on while cw on");
   chk_free_cut: assert property (shaft_release_input |-> ##3 (current_cut && deviation_clear))
      else $error("shaft release did not cut current");
   chk_motion_min: assert property ($fell(motion_active_output) |-> on_cnt_r >= MIN_CYC)
      else $error("motion active too short");
   chk_speed_limit: assert property ($past(arst_n) && $stable(speed_limit_value)
      |-> speed_limited_output == ($past(detected_speed) >= speed_limit_value))
      else $error("speed limited output wrong");
   chk_zero_band: assert property (zero_speed_output |-> $past(detected_speed) <= 13'h000a)
      else $error("zero speed outside band");
   chk_dia_hold: assert property ((motor_running && !roll_rev_pulse)[*5] |=> $stable(diameter_um))
      else $error("diameter changed while running");
   chk_decel_stop: assert property ($fell(cw_in) ##1 (!cw_in && motor_running)[*3]
      |-> decel_request && !motor_enable)
      else $error("no deceleration after cw off");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside read cycle");
endmodule

bind tmc_io_ctrl tmc_io_ctrl_chk #(.MS_CYC(MS_CYC)) tmc_io_ctrl_chk_inst (
   .ref_clk, .arst_n, .cw_in, .shaft_release_input, .alarm_active, .motor_running,
   .roll_rev_pulse, .detected_speed, .reg_rd, .reg_rdata, .ready_output,
   .motion_active_output, .speed_limited_output, .zero_speed_output, .motor_enable,
   .decel_request, .current_cut, .deviation_clear, .speed_limit_value, .diameter_um
);
`default_nettype wire

// [dv/tmc_plc_model.sv]
// controller model: switches its brake from the brake release line
// assumes the line is a registered level on ref_clk
`timescale 1ns/1ps
`default_nettype none
module tmc_plc_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // line from the drive
   input  wire logic brake_release_output,
   // brake state, high = holding the load
   output var logic  brake_hold_r
);
   // ****************************
   // brake coil
   // ****************************
   // unpowered brake holds, so reset means holding
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         brake_hold_r <= 1'b1;
      else
         brake_hold_r <= !brake_release_output;
   end
endmodule
`default_nettype wire

// [dv/tension_mode_io_control_bench.sv]
// self-checking bench for the tension mode discrete i/o block
// assumes tmc_io_ctrl, its checker and the controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tension_mode_io_control_bench;
   typedef struct packed {
      logic [6:0] pins;
      logic       rdy;
      logic       en;
      logic       cut;
      logic       dir;
   } tmc_row_t;
   localparam int MS_CYC = 10;
   logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, cw_in = 1'b0, ccw_in = 1'b0;
   logic diameter_reset_input = 1'b0, shaft_release_input = 1'b0, alarm_active = 1'b0;
   logic data_select_bit0 = 1'b0, data_select_bit1 = 1'b0, data_select_bit2 = 1'b0;
   logic remote_active = 1'b0, test_active = 1'b0, copy_active = 1'b0;
   logic motor_running = 1'b0, roll_rev_pulse = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [12:0] detected_speed = 13'h0000, internal_speed_pot = 13'h007b;
   logic [12:0] external_speed_in = 13'h01c8;
   logic [9:0]  reg_addr = 10'h000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   wire [31:0]  reg_rdata;
   wire ready_output, motion_active_output, brake_release_output, speed_limited_output;
   wire zero_speed_output, motor_enable, motor_dir, decel_request, current_cut;
   wire deviation_clear, brake_hold_r;
   wire [12:0]  speed_limit_value;
   wire [23:0]  diameter_um;
   int err_total = 0, n_compared = 0;
   // pins: alarm remote test copy cw ccw free
   tmc_row_t rows [9] = '{'{7'h00, 1'h1, 1'h0, 1'h0, 1'h0}, '{7'h40, 1'h0, 1'h0, 1'h0, 1'h0},
      '{7'h20, 1'h0, 1'h0, 1'h0, 1'h0}, '{7'h10, 1'h0, 1'h0, 1'h0, 1'h0},
      '{7'h08, 1'h0, 1'h0, 1'h0, 1'h0}, '{7'h04, 1'h0, 1'h1, 1'h0, 1'h0},
      '{7'h02, 1'h0, 1'h1, 1'h0, 1'h1}, '{7'h44, 1'h0, 1'h0, 1'h0, 1'h0},
      '{7'h01, 1'h0, 1'h0, 1'h1, 1'h0}};
   logic [9:0]  ra [10] = '{10'h000, 10'h004, 10'h008, 10'h010, 10'h108, 10'h10c, 10'h110,
      10'h114, 10'h1e8, 10'h3fc};
   logic [31:0] rv [10] = '{32'h0000_0004, 32'h0000_000a, 32'h0000_000a, 32'h0000_0000,
      32'h0000_0032, 32'h0000_01f4, 32'h0000_03e8, 32'h0000_0064, 32'h0000_0032, 32'h0000_0000};

   always #2.5 ref_clk = ~ref_clk;

   tmc_io_ctrl #(.MS_CYC(MS_CYC)) tmc_io_ctrl_inst (
      .ref_clk, .arst_n, .clk_en, .cw_in, .ccw_in, .diameter_reset_input, .shaft_release_input,
      .data_select_bit0, .data_select_bit1, .data_select_bit2, .alarm_active, .remote_active,
      .test_active, .copy_active, .motor_running, .roll_rev_pulse, .detected_speed,
      .internal_speed_pot, .external_speed_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .ready_output, .motion_active_output, .brake_release_output,
      .speed_limited_output, .zero_speed_output, .motor_enable, .motor_dir, .decel_request,
      .current_cut, .deviation_clear, .speed_limit_value, .tension_cmd(), .thickness_cmd(),
      .taper_cmd(), .mat_inertia_cmd(), .core_inertia_cmd(), .diameter_um
   );
   tmc_plc_model tmc_plc_model_inst (.ref_clk, .arst_n, .brake_release_output, .brake_hold_r);

   // ****************************
   // tasks
   // ****************************
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_write(input logic [9:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_check(input logic [9:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      cmp_word("reg_rdata", exp, reg_rdata);
   endtask
   task automatic pins(input logic [6:0] v);
      @(posedge ref_clk);
      {alarm_active, remote_active, test_active, copy_active, cw_in, ccw_in,
       shaft_release_input} <= v;
      settle(5);
   endtask
   task automatic sel(input logic [2:0] s);
      @(posedge ref_clk);
      {data_select_bit2, data_select_bit1, data_select_bit0} <= s;
      settle(5);
   endtask
   // one-cycle pulse on diameter reset (dia=1) or roll revolution (dia=0)
   task automatic pulse(input logic dia);
      @(posedge ref_clk);
      diameter_reset_input <= dia;
      roll_rev_pulse <= !dia;
      @(posedge ref_clk);
      diameter_reset_input <= 1'b0;
      roll_rev_pulse <= 1'b0;
      settle(5);
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ****************************
   // tests
   // ****************************
   initial begin
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         pins(rows[i].pins);
         cmp_bit("ready_output", rows[i].rdy, ready_output);
         cmp_bit("motor_enable", rows[i].en, motor_enable);
         cmp_bit("current_cut", rows[i].cut, current_cut);
         if (rows[i].en)
            cmp_bit("motor_dir", rows[i].dir, motor_dir);
      end
      reg_write(10'h010, 32'h0000_1234);
      foreach (ra[i])
         reg_check(ra[i], rv[i]);
      pins(7'h00);
      reg_write(10'h000, 32'h0000_0000);
      for (int s = 0; s < 8; s++)
         reg_write(10'h100 + 10'(s * 32), 32'(100 + s));
      for (int s = 0; s < 8; s++) begin
         sel(3'(s));
         cmp_word("speed_limit_value", 32'(100 + s), 32'(speed_limit_value));
      end
      sel(3'h5);
      detected_speed <= 13'h0068;
      settle(3);
      cmp_bit("speed_limited_output", 1'b0, speed_limited_output);
      detected_speed <= 13'h0069;
      settle(3);
      cmp_bit("speed_limited_output", 1'b1, speed_limited_output);
      reg_write(10'h000, 32'h0000_0004);
      sel(3'h0);
      cmp_word("speed_limit_value", 32'h0000_007b, 32'(speed_limit_value));
      sel(3'h1);
      cmp_word("speed_limit_value", 32'h0000_01c8, 32'(speed_limit_value));
      sel(3'h2);
      pins(7'h04);
      sel(3'h6);
      cmp_word("speed_limit_value", 32'h0000_0066, 32'(speed_limit_value));
      motor_running <= 1'b1;
      pins(7'h00);
      cmp_bit("decel_request", 1'b1, decel_request);
      cmp_bit("motor_enable", 1'b0, motor_enable);
      motor_running <= 1'b0;
      reg_write(10'h000, 32'h0000_0005);
      reg_write(10'h16c, 32'h0000_03e8);
      reg_write(10'h170, 32'h0000_01f4);
      sel(3'h0);
      pulse(1'b1);
      cmp_word("diameter_um", 32'h0007_a120, 32'(diameter_um));
      motor_running <= 1'b1;
      pulse(1'b0);
      cmp_word("diameter_um", 32'h0007_a184, 32'(diameter_um));
      motor_running <= 1'b0;
      sel(3'h3);
      pulse(1'b1);
      motor_running <= 1'b1;
      pulse(1'b0);
      cmp_word("diameter_um", 32'h000f_41dc, 32'(diameter_um));
      pulse(1'b1);
      cmp_word("diameter_um", 32'h000f_41dc, 32'(diameter_um));
      motor_running <= 1'b0;
      pins(7'h02);
      cmp_bit("motor_enable", 1'b0, motor_enable);
      pins(7'h00);
      settle(110);
      reg_write(10'h000, 32'h0000_0014);
      motor_running <= 1'b1;
      settle(2);
      motor_running <= 1'b0;
      settle(60);
      cmp_bit("motion_active_output", 1'b1, motion_active_output);
      settle(62);
      cmp_bit("motion_active_output", 1'b0, motion_active_output);
      reg_write(10'h000, 32'h0000_0024);
      settle(3);
      cmp_bit("brake_hold_r", 1'b1, brake_hold_r);
      pins(7'h01);
      cmp_bit("brake_release_output", 1'b1, brake_release_output);
      cmp_bit("brake_hold_r", 1'b0, brake_hold_r);
      pins(7'h00);
      reg_write(10'h000, 32'h0000_0044);
      detected_speed <= 13'h0005;
      settle(3);
      cmp_bit("zero_speed_output", 1'b1, zero_speed_output);
      detected_speed <= 13'h00c8;
      settle(3);
      cmp_bit("zero_speed_output", 1'b0, zero_speed_output);
      arst_n <= 1'b0;
      settle(2);
      cmp_bit("ready_output", 1'b0, ready_output);
      arst_n <= 1'b1;
      reg_check(10'h000, 32'h0000_0004);
      final_report();
   end

   // hang guard, far beyond the roughly 540 cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      $display("BAD watchdog expected done seen hang");
      final_report();
   end
endmodule
`default_nettype wire
